// *** adc_seq_pkg.sv ***
// Package: constants and types for the converter sequencer
`default_nettype none
package adc_seq_pkg;
   localparam logic [5:0] CYC_10_SH    = 6'd33;
   localparam logic [5:0] CYC_8_SH     = 6'd28;
   localparam logic [5:0] CYC_10_NOSH  = 6'd59;
   localparam logic [5:0] CYC_8_NOSH   = 6'd49;
   localparam logic [5:0] SAMPLE_CYC   = 6'd3;
   localparam logic [3:0] MSB_BIT      = 4'h9;
   localparam logic [3:0] LSB_10BIT    = 4'h0;
   localparam logic [3:0] LSB_8BIT     = 4'h2;
   localparam logic [2:0] SYNC_RESET   = 3'h7;
   localparam logic [1:0] DIV_RESET    = 2'h0;
   localparam logic [9:0] RESULT_RESET = 10'h000;
   localparam int         NUM_CH       = 8;

   typedef enum logic [1:0] {
      MODE_ONESHOT,
      MODE_EXPANSION,
      MODE_AMPLIFIER,
      MODE_REPEAT
   } conv_mode_t;

   typedef enum logic [1:0] {
      CLK_DIV4,
      CLK_DIV2,
      CLK_DIV1,
      CLK_RSVD
   } clk_sel_t;

   typedef struct packed {
      conv_mode_t mode;
      clk_sel_t   clk_sel;
      logic       res_10bit;
      logic       sample_hold;
      logic       ext_trigger;
      logic [2:0] channel;
      logic       expansion_input_sel;
   } conv_cfg_t;
endpackage
`default_nettype wire

// *** adc_seq.sv ***
// Converter control sequencer: one-shot, triggered, expansion, amplifier and repeat
`default_nettype none
module adc_seq (
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire adc_seq_pkg::conv_cfg_t cfg_i,
   input  wire logic                 start_set_i,
   input  wire logic                 start_clr_i,
   input  wire logic                 ext_trigger_pin_i,
   input  wire logic                 comparator_i,
   input  wire logic                 irq_clr_i,
   output logic                      start_flag_o,
   output logic                      busy_o,
   output logic                      irq_o,
   output logic                      sampling_o,
   output logic [9:0]                dac_code_o,
   output logic [2:0]                selected_channel_pin_o,
   output logic                      expansion_out_pin_o,
   output logic                      expansion_in_pin_o,
   output logic                      expansion_input_sel_o,
   output logic [9:0]                result_o [adc_seq_pkg::NUM_CH],
   output logic [9:0]                expansion_result_o
);
   import adc_seq_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} state_t;

   // ----------------------------------------------------------------
   // Operating clock enable
   // ----------------------------------------------------------------
   // Divider runs free, so the first tick of a conversion may land up to three clocks late
   logic [1:0] div_reg;
   logic [1:0] div_next;
   wire        tick = (cfg_i.clk_sel == CLK_DIV1) ||
                      (cfg_i.clk_sel == CLK_DIV2 && div_reg[0]) ||
                      (div_reg == 2'h3);
   assign div_next = div_reg + 2'h1;

   // ----------------------------------------------------------------
   // Trigger synchroniser
   // ----------------------------------------------------------------
   // Pin idles high, so the chain is preset high and no edge appears out of reset
   logic [2:0] trig_sync_reg;
   logic       trig_stable_reg;
   wire        trig_agree = (trig_sync_reg[1] == trig_sync_reg[2]);
   wire        trig_fall  = trig_agree && trig_stable_reg && !trig_sync_reg[2];

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   state_t     state_reg;
   logic [5:0] cyc_reg;
   logic [3:0] bit_reg;
   logic [9:0] sar_reg;
   logic       start_reg;
   logic       irq_reg;
   logic [9:0] result_reg [NUM_CH];
   logic [9:0] exp_result_reg;
   // Blocks a software relaunch in the cycle that the automatic clear lands
   logic       done_hold_reg;

   wire [5:0] total_cyc = cfg_i.sample_hold ?
                          (cfg_i.res_10bit ? CYC_10_SH : CYC_8_SH) :
                          (cfg_i.res_10bit ? CYC_10_NOSH : CYC_8_NOSH);
   wire [3:0] low_bit   = cfg_i.res_10bit ? LSB_10BIT : LSB_8BIT;
   wire       trig_mode = cfg_i.ext_trigger && cfg_i.mode == MODE_ONESHOT;
   wire       go_soft   = !trig_mode && start_reg && state_reg == ST_IDLE && !done_hold_reg;
   wire       go_trig   = trig_mode && start_reg && trig_fall;
   wire       launch    = go_soft || go_trig;
   wire       last_cyc  = state_reg == ST_CONVERT && tick && cyc_reg == total_cyc - 6'd1;
   wire [9:0] sar_try   = sar_reg | (10'h001 << bit_reg);
   wire [9:0] final_val = comparator_i ? sar_try : sar_reg;
   wire [9:0] stored    = cfg_i.res_10bit ? final_val : {final_val[9:2], 2'h0};
   wire       one_shot  = cfg_i.mode != MODE_REPEAT;
   wire       clear_flag = last_cyc && (cfg_i.mode == MODE_EXPANSION ||
                                        cfg_i.mode == MODE_AMPLIFIER ||
                                        (cfg_i.mode == MODE_ONESHOT && !trig_mode));
   wire       irq_set = last_cyc && one_shot;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         div_reg         <= DIV_RESET;
         trig_sync_reg   <= SYNC_RESET;
         trig_stable_reg <= 1'b1;
         state_reg       <= ST_IDLE;
         cyc_reg         <= 6'h00;
         bit_reg         <= MSB_BIT;
         sar_reg         <= RESULT_RESET;
         start_reg       <= 1'b0;
         irq_reg         <= 1'b0;
         done_hold_reg   <= 1'b0;
         exp_result_reg  <= RESULT_RESET;
         for (int i = 0; i < NUM_CH; i++) begin
            result_reg[i] <= RESULT_RESET;
         end
      end else begin
         div_reg       <= div_next;
         trig_sync_reg <= {trig_sync_reg[1:0], ext_trigger_pin_i};
         if (trig_agree) begin
            trig_stable_reg <= trig_sync_reg[2];
         end
         // Set wins over clear for both flags
         if (start_set_i) begin
            start_reg <= 1'b1;
         end else if (start_clr_i || clear_flag) begin
            start_reg <= 1'b0;
         end
         if (irq_set) begin
            irq_reg <= 1'b1;
         end else if (irq_clr_i) begin
            irq_reg <= 1'b0;
         end
         // Holds off a software relaunch until the flag is seen cleared or set again
         done_hold_reg <= clear_flag ? 1'b1 : (done_hold_reg && start_reg && !start_set_i);
         if (launch) begin
            state_reg <= cfg_i.sample_hold ? ST_SAMPLE : ST_CONVERT;
            cyc_reg   <= 6'h00;
            bit_reg   <= MSB_BIT;
            sar_reg   <= RESULT_RESET;
         end else if (state_reg != ST_IDLE && !trig_mode && !start_reg) begin
            state_reg <= ST_IDLE;
         end else if (tick) begin
            case (state_reg)
               ST_SAMPLE: begin
                  cyc_reg <= cyc_reg + 6'h01;
                  if (cyc_reg == SAMPLE_CYC - 6'd1) begin
                     state_reg <= ST_CONVERT;
                  end
               end
               ST_CONVERT: begin
                  cyc_reg <= cyc_reg + 6'h01;
                  if (last_cyc) begin
                     if (cfg_i.mode == MODE_EXPANSION) begin
                        exp_result_reg <= stored;
                     end else begin
                        result_reg[cfg_i.channel] <= stored;
                     end
                     cyc_reg   <= 6'h00;
                     bit_reg   <= MSB_BIT;
                     sar_reg   <= RESULT_RESET;
                     state_reg <= one_shot ? ST_IDLE :
                                  (cfg_i.sample_hold ? ST_SAMPLE : ST_CONVERT);
                  end else if (bit_reg >= low_bit && cyc_reg >= SAMPLE_CYC) begin
                     // One bit decided per cycle, MSB first, after settling
                     if (comparator_i) begin
                        sar_reg <= sar_try;
                     end
                     if (bit_reg != low_bit) begin
                        bit_reg <= bit_reg - 4'h1;
                     end
                  end
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs and analog routing
   // ----------------------------------------------------------------
   wire active = state_reg != ST_IDLE;
   assign start_flag_o           = start_reg;
   assign busy_o                 = active;
   assign irq_o                  = irq_reg;
   assign sampling_o             = state_reg == ST_SAMPLE;
   assign dac_code_o             = sar_try;
   assign selected_channel_pin_o = cfg_i.channel;
   assign expansion_out_pin_o    = active && (cfg_i.mode == MODE_AMPLIFIER ||
                                   (cfg_i.mode == MODE_EXPANSION && !cfg_i.expansion_input_sel));
   assign expansion_in_pin_o     = active && (cfg_i.mode == MODE_AMPLIFIER ||
                                   (cfg_i.mode == MODE_EXPANSION && cfg_i.expansion_input_sel));
   assign expansion_input_sel_o  = cfg_i.expansion_input_sel;
   assign result_o               = result_reg;
   assign expansion_result_o     = exp_result_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Settings only change between conversions, so antecedents read them live

   chk_trig_launch: assert property (go_trig |=> state_reg != ST_IDLE && cyc_reg == 6'h00)
      else $error("trigger edge did not launch");
   chk_trig_restart: assert property (go_trig && active |=> cyc_reg == 6'h00)
      else $error("trigger did not restart conversion");
   chk_irq_oneshot: assert property (last_cyc && one_shot && !irq_clr_i |=> irq_reg)
      else $error("one-shot completion missed request");
   chk_repeat_noirq: assert property (!irq_reg && cfg_i.mode == MODE_REPEAT && $stable(cfg_i.mode) |=> !irq_reg)
      else $error("repeat mode raised request");
   chk_flag_clear: assert property (clear_flag && !start_set_i |=> !start_reg)
      else $error("start flag not cleared");
   chk_repeat_stop: assert property (start_clr_i && !start_set_i && !trig_mode |=> ##1 !active)
      else $error("repeat did not stop");
   chk_div_four: assert property (tick && cfg_i.clk_sel == CLK_DIV4 |=>
      !(tick && cfg_i.clk_sel == CLK_DIV4) [*3])
      else $error("divide by four wrong");
   chk_fall_pulse: assert property (trig_fall |=> !trig_fall)
      else $error("trigger edge not single pulse");
   chk_amp_route: assert property (active && cfg_i.mode == MODE_AMPLIFIER |-> expansion_out_pin_o && expansion_in_pin_o)
      else $error("amplifier routing missing");
   chk_8bit_low: assert property (last_cyc && !cfg_i.res_10bit |-> stored[1:0] == 2'h0)
      else $error("8-bit result has low bits");
   chk_soft_halt: assert property (last_cyc && one_shot && !go_trig |=> !active)
      else $error("one-shot did not halt");
   chk_repeat_wrap: assert property (last_cyc && cfg_i.mode == MODE_REPEAT && start_reg |=> active)
      else $error("repeat did not continue");
   chk_exp_store: assert property (last_cyc && cfg_i.mode == MODE_EXPANSION && start_reg |=>
      exp_result_reg == $past(stored))
      else $error("expansion result not stored");
   chk_start_set: assert property (start_set_i |=> start_reg)
      else $error("start flag set lost");
   chk_irq_clear: assert property (irq_clr_i && !irq_set |=> !irq_reg)
      else $error("request not cleared");

   cov_trig_restart: cover property (go_trig && active);
   cov_repeat_two: cover property (last_cyc && cfg_i.mode == MODE_REPEAT ##[1:300] last_cyc);
   cov_expansion_done: cover property (last_cyc && cfg_i.mode == MODE_EXPANSION);
   cov_amp_done: cover property (last_cyc && cfg_i.mode == MODE_AMPLIFIER);
   cov_trig_done: cover property (last_cyc && trig_mode);
endmodule
`default_nettype wire

// *** analog_src.sv ***
// Behavioural far side: analog level on the selected input versus the trial code
`default_nettype none
module analog_src (
   input  wire logic [9:0] dac_code_i,
   input  wire logic [9:0] level_i,
   output logic            comparator_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // High while the held input is at or above the trial code, so the search lands on the level
   assign comparator_o = (level_i >= dac_code_i);
endmodule
`default_nettype wire

// *** tb_adc_oneshot_repeat_sequencer.sv ***
// Self-checking bench for the converter sequencer
`default_nettype none
module tb_adc_oneshot_repeat_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   import adc_seq_pkg::*;
   logic       clk_i = 1'b0, rst_n_i, start_set_i, start_clr_i, pin, irq_clr_i, comp;
   conv_cfg_t  cfg_i;
   logic [9:0] level, dac, res [NUM_CH], xres;
   logic [2:0] ch;
   logic       sflag, busy, irq, samp, xout, xin, xsel;
   int         errors = 0, cmp_count = 0, cycles = 0, n, e, i;
   // ---------------------------------------------------------------
   // Design and far side
   // ---------------------------------------------------------------
   adc_seq u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg_i), .start_set_i(start_set_i),
      .start_clr_i(start_clr_i), .ext_trigger_pin_i(pin), .comparator_i(comp), .irq_clr_i(irq_clr_i),
      .start_flag_o(sflag), .busy_o(busy), .irq_o(irq), .sampling_o(samp), .dac_code_o(dac),
      .selected_channel_pin_o(ch), .expansion_out_pin_o(xout), .expansion_in_pin_o(xin),
      .expansion_input_sel_o(xsel), .result_o(res), .expansion_result_o(xres));
   analog_src u_src (.dac_code_i(dac), .level_i(level), .comparator_o(comp));
   initial forever #25 clk_i = ~clk_i;
   // Hang guard: the whole sequence needs well under this many cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         summarize();
      end
   end
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic summarize;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic int exp_cyc(conv_cfg_t c);
      int b;
      b = c.sample_hold ? (c.res_10bit ? 33 : 28) : (c.res_10bit ? 59 : 49);
      return b * (c.clk_sel == CLK_DIV4 ? 4 : c.clk_sel == CLK_DIV2 ? 2 : 1);
   endfunction
   function automatic logic [9:0] exp_res(logic [9:0] l, logic r10);
      return r10 ? l : {l[9:2], 2'h0};
   endfunction
   // Loose window: edge latencies around the conversion body are the designer's choice
   function automatic logic [9:0] near(int got, int exp);
      return {9'h0, (got + 8 >= exp) && (got <= exp + 8)};
   endfunction
   task automatic rand_cfg(input conv_mode_t m, input logic trig);
      @(negedge clk_i);
      irq_clr_i = 1'b1;
      start_clr_i = 1'b1;
      @(negedge clk_i);
      irq_clr_i = 1'b0;
      start_clr_i = 1'b0;
      cfg_i = conv_cfg_t'(11'($urandom));
      cfg_i.mode = m;
      cfg_i.ext_trigger = trig;
      cfg_i.clk_sel = clk_sel_t'($urandom_range(2, 0));
      level = 10'($urandom);
   endtask
   task automatic pulse_start;
      @(negedge clk_i) start_set_i = 1'b1;
      @(negedge clk_i) start_set_i = 1'b0;
   endtask
   task automatic wait_done(output int cnt);
      int k;
      k = 0;
      cnt = 0;
      while (busy !== 1'b1 && k < 20) begin
         @(negedge clk_i);
         k++;
      end
      while (busy === 1'b1 && cnt < 2000) begin
         @(negedge clk_i);
         cnt++;
      end
      @(negedge clk_i);
   endtask
   task automatic trig_fall;
      @(negedge clk_i) pin = 1'b0;
      repeat (4) @(negedge clk_i);
      pin = 1'b1;
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {start_set_i, start_clr_i, irq_clr_i, level} = '0;
      cfg_i = '0;
      pin = 1'b1;
      rst_n_i = 1'b0;
      void'($urandom(32'hdc26));
      repeat (2) @(negedge clk_i);
      rst_n_i = 1'b1;
      chk({irq, sflag, busy}, 10'h0);
      chk(res[0], RESULT_RESET);
      for (i = 0; i < 12; i++) begin
         rand_cfg(i % 2 ? MODE_AMPLIFIER : MODE_EXPANSION, 1'b0);
         pulse_start();
         repeat (3) @(negedge clk_i);
         chk({busy, samp}, {8'h0, 1'b1, cfg_i.sample_hold});
         if (i % 2) chk({xout, xin, xsel}, {7'h0, 2'h3, cfg_i.expansion_input_sel});
         else chk({xout, xin, xsel}, {7'h0, !cfg_i.expansion_input_sel, {2{cfg_i.expansion_input_sel}}});
         wait_done(n);
         chk(near(n, exp_cyc(cfg_i)), 10'h1);
         chk({irq, sflag}, 10'h2);
         chk({xout, xin}, 10'h0);
         chk(ch, cfg_i.channel);
         if (i % 2) chk(res[cfg_i.channel], exp_res(level, cfg_i.res_10bit));
         else chk(xres, exp_res(level, cfg_i.res_10bit));
      end
      rand_cfg(MODE_ONESHOT, 1'b1);
      cfg_i.clk_sel = CLK_DIV1;
      pulse_start();
      repeat (8) @(negedge clk_i);
      chk({busy, sflag}, 10'h1);
      for (i = 0; i < 3; i++) begin
         level = 10'($urandom);
         irq_clr_i = 1'b1;
         @(negedge clk_i) irq_clr_i = 1'b0;
         trig_fall();
         wait_done(n);
         chk(res[cfg_i.channel], exp_res(level, cfg_i.res_10bit));
         chk({irq, busy}, 10'h2);
      end
      trig_fall();
      repeat (10) @(negedge clk_i);
      trig_fall();
      wait_done(n);
      chk(near(n, exp_cyc(cfg_i)), 10'h1);
      rand_cfg(MODE_REPEAT, 1'b0);
      e = exp_cyc(cfg_i);
      pulse_start();
      repeat (e + 10) @(negedge clk_i);
      chk(res[cfg_i.channel], exp_res(level, cfg_i.res_10bit));
      level = ~level;
      repeat (2 * e + 10) @(negedge clk_i);
      chk(res[cfg_i.channel], exp_res(level, cfg_i.res_10bit));
      chk({irq, busy, sflag}, 10'h3);
      @(negedge clk_i) start_clr_i = 1'b1;
      @(negedge clk_i) start_clr_i = 1'b0;
      repeat (3) @(negedge clk_i);
      chk({busy, sflag}, 10'h0);
      summarize();
   end
endmodule
`default_nettype wire
